// File: rtl/acs_regs.vh
// register map, field positions, codes and timing counts of the
// calibration sequencer; assumes inclusion by bare name from rtl/.
`ifndef ACS_REGS_VH
`define ACS_REGS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define ACS_OFS_MODE    12'h000
`define ACS_OFS_FILTER  12'h004
`define ACS_OFS_STATUS  12'h008
`define ACS_OFS_OFFS0   12'h00C
`define ACS_OFS_OFFS1   12'h010
`define ACS_OFS_GAIN0   12'h014
`define ACS_OFS_GAIN1   12'h018

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ACS_MODE_OP_LSB   0
`define ACS_MODE_OP_MSB   2
`define ACS_MODE_RNG_LSB  3
`define ACS_MODE_RNG_MSB  4
`define ACS_MODE_BIP      5
`define ACS_MODE_CHAN     6
`define ACS_FILT_CHOP     0
`define ACS_FILT_AC       1
`define ACS_FILT_DIV_LSB  16
`define ACS_FILT_DIV_MSB  31

// ----------------------------------------------------------------
// operating-mode codes
// ----------------------------------------------------------------
`define ACS_OP_IDLE   3'h0
`define ACS_OP_CONT   3'h1
`define ACS_OP_SINGLE 3'h2
`define ACS_OP_IZS    3'h4
`define ACS_OP_IFS    3'h5
`define ACS_OP_SZS    3'h6

// ----------------------------------------------------------------
// reset values and timing counts (output-word periods per step)
// ----------------------------------------------------------------
`define ACS_RST_COEF_OFFS 24'h800000
`define ACS_RST_COEF_GAIN 24'h800000
`define ACS_RST_DIV       16'h0400
`define ACS_MIDSCALE      24'h800000
`define ACS_STEP_CHOP     6'h16
`define ACS_STEP_NOCHOP   6'h18

`endif

// File: rtl/acs_word_timer.v
// output-word period divider for the calibration sequencer;
// assumes pclk and an asynchronous active-low reset.
`timescale 1ns/1ns

module acs_word_timer (
    pclk,
    presetn,
    start,
    run,
    div,
    tick
);
    input  wire        pclk;
    input  wire        presetn;
    input  wire        start;
    input  wire        run;
    input  wire [15:0] div;
    output reg         tick;

    reg  [15:0] div_r;
    reg  [15:0] cnt_r;

    // ------------------------------------------------------------
    // period latched at start so a later rate change cannot
    // stretch or shrink a running calibration
    // ------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= 16'h0001;
            cnt_r <= 16'h0000;
            tick  <= 1'b0;
        end else if (start) begin
            div_r <= (div == 16'h0000) ? 16'h0001 : div;
            cnt_r <= 16'h0000;
            tick  <= 1'b0;
        end else if (run) begin
            if (cnt_r + 16'h0001 >= div_r) begin
                cnt_r <= 16'h0000;
                tick  <= 1'b1;
            end else begin
                cnt_r <= cnt_r + 16'h0001;
                tick  <= 1'b0;
            end
        end else begin
            cnt_r <= 16'h0000;
            tick  <= 1'b0;
        end
    end
endmodule // acs_word_timer

// File: rtl/acs_corrector.v
// applies offset and gain coefficients to filter words;
// assumes filter words arrive on pclk with a one-cycle valid.
`timescale 1ns/1ns

`include "acs_regs.vh"

module acs_corrector (
    pclk,
    presetn,
    in_valid,
    in_data,
    enable,
    bipolar,
    offs,
    gain,
    out_valid,
    out_data
);
    input  wire        pclk;
    input  wire        presetn;
    input  wire        in_valid;
    input  wire [23:0] in_data;
    input  wire        enable;
    input  wire        bipolar;
    input  wire [23:0] offs;
    input  wire [23:0] gain;
    output reg         out_valid;
    output reg  [23:0] out_data;

    wire signed [24:0] diff;
    wire signed [49:0] prod;
    wire        [23:0] scaled;

    // offset removed first, then scaled; gain 800000 is unity
    assign diff   = $signed({1'b0, in_data}) - $signed({1'b0, offs});
    assign prod   = diff * $signed({1'b0, gain});
    assign scaled = prod[46:23];

    // ------------------------------------------------------------
    // bipolar: zero input lands on midscale
    // ------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_valid <= 1'b0;
            out_data  <= 24'h000000;
        end else begin
            out_valid <= in_valid & enable;
            if (in_valid & enable) begin
                out_data <= bipolar ? scaled + `ACS_MIDSCALE
                                    : scaled;
            end
        end
    end
endmodule // acs_corrector

// File: rtl/acs_cal_seq.v
// calibration sequencer of a bridge-transducer sigma-delta converter:
// mode register, calibration timing, coefficient store, ready line.
// assumes an APB master on pclk and a filter that delivers words
// on pclk; analogue switches are driven from the control outputs.
//
// Behaviour
// - code 100 starts internal zero-scale calibration
// - internal zero-scale shorts the input pair
// - gain follows range bits during calibration
// - internal calibrations force dc excitation
// - zero-scale lasts 22 or 24 word periods
// - mode code returns to idle when done
// - ready high during calibration, low after
// - zero-scale updates offset only, no result
// - ready may lag one modulator cycle
// - bipolar zero reads as midscale 800000
// - code 101 starts internal full-scale calibration
// - full-scale voltage derived from reference
// - full-scale runs two steps, rewrites offset
// - full-scale lasts 44 or 48 periods
// - code 110 starts system zero-scale calibration
// - system zero-scale excitation follows ac bit
// - bipolar system zero maps to midpoint
// - coefficients 24-bit per channel, host access
// - offset subtracted before gain multiply
`timescale 1ns/1ns

`include "acs_regs.vh"

module acs_cal_seq (
    pclk,
    presetn,
    psel,
    penable,
    pwrite,
    paddr,
    pwdata,
    prdata,
    pready,
    pslverr,
    filt_valid,
    filt_data,
    ready_n,
    input_short,
    fs_ref_sel,
    pga_range,
    ac_excite,
    corr_valid,
    corr_data
);
    input  wire        pclk;
    input  wire        presetn;
    input  wire        psel;
    input  wire        penable;
    input  wire        pwrite;
    input  wire [11:0] paddr;
    input  wire [31:0] pwdata;
    output reg  [31:0] prdata;
    output reg         pready;
    output reg         pslverr;
    input  wire        filt_valid;
    input  wire [23:0] filt_data;
    output reg         ready_n;
    output reg         input_short;
    output reg         fs_ref_sel;
    output reg  [1:0]  pga_range;
    output reg         ac_excite;
    output wire        corr_valid;
    output wire [23:0] corr_data;

    // ------------------------------------------------------------
    // state codes
    // ------------------------------------------------------------
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_ZERO = 2'h1;
    localparam [1:0] ST_FULL = 2'h2;

    // address decode, shared by read and write paths
    function mapped;
        input [11:0] a;
        begin
            mapped = (a == `ACS_OFS_MODE)  || (a == `ACS_OFS_FILTER) ||
                     (a == `ACS_OFS_STATUS)|| (a == `ACS_OFS_OFFS0)  ||
                     (a == `ACS_OFS_OFFS1) || (a == `ACS_OFS_GAIN0)  ||
                     (a == `ACS_OFS_GAIN1);
        end
    endfunction

    // calibration command decode
    function is_cal;
        input [2:0] op;
        begin
            is_cal = (op == `ACS_OP_IZS) || (op == `ACS_OP_IFS) ||
                     (op == `ACS_OP_SZS);
        end
    endfunction

    reg  [2:0]  op_code_r;
    reg  [1:0]  range_r;
    reg         bipolar_r;
    reg         chan_r;
    reg         chop_enable_r;
    reg         ac_excitation_enable_r;
    reg  [15:0] word_div_r;
    reg  [23:0] offs_r [0:1];
    reg  [23:0] gain_r [0:1];
    reg  [1:0]  state_r;
    reg  [1:0]  state_nxt;
    reg  [5:0]  step_len_r;
    reg  [5:0]  tick_cnt_r;
    reg         two_step_r;
    reg         cal_chan_r;
    reg  [23:0] sample_r;
    reg         sample_ok_r;

    wire        wr_en;
    wire        rd_en;
    wire        mode_wr;
    wire        cal_start;
    wire        word_tick;
    wire        step_done;
    wire        conv_on;
    wire [31:0] status_w;

    // ------------------------------------------------------------
    // APB handshake
    // ------------------------------------------------------------
    // one wait state so read data can come from a flop
    assign wr_en   = psel & penable & pready & pwrite;
    assign rd_en   = psel & penable & ~pready & ~pwrite;
    assign mode_wr = wr_en & (paddr == `ACS_OFS_MODE);
    assign cal_start = mode_wr &
                       is_cal(pwdata[`ACS_MODE_OP_MSB:`ACS_MODE_OP_LSB]);

    // pready and error flag
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~mapped(paddr);
        end
    end

    assign status_w = {26'h0, cal_chan_r, two_step_r, state_r,
                       chop_enable_r, ready_n};

    // read data captured in the wait cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (rd_en) begin
            case (paddr)
                `ACS_OFS_MODE: begin
                    prdata <= {25'h0, chan_r, bipolar_r, range_r,
                               op_code_r};
                end
                `ACS_OFS_FILTER: begin
                    prdata <= {word_div_r, 14'h0,
                               ac_excitation_enable_r, chop_enable_r};
                end
                `ACS_OFS_STATUS: prdata <= status_w;
                `ACS_OFS_OFFS0:  prdata <= {8'h00, offs_r[0]};
                `ACS_OFS_OFFS1:  prdata <= {8'h00, offs_r[1]};
                `ACS_OFS_GAIN0:  prdata <= {8'h00, gain_r[0]};
                `ACS_OFS_GAIN1:  prdata <= {8'h00, gain_r[1]};
                default:         prdata <= 32'h00000000;
            endcase
        end else if (pready) begin
            prdata <= 32'h00000000;
        end
    end

    // ------------------------------------------------------------
    // mode and filter configuration
    // ------------------------------------------------------------
    // a host write wins over the end-of-calibration clear, so a
    // command issued in the finishing cycle is never lost
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_code_r <= `ACS_OP_IDLE;
            range_r   <= 2'h0;
            bipolar_r <= 1'b0;
            chan_r    <= 1'b0;
        end else if (mode_wr) begin
            op_code_r <= pwdata[`ACS_MODE_OP_MSB:`ACS_MODE_OP_LSB];
            range_r   <= pwdata[`ACS_MODE_RNG_MSB:`ACS_MODE_RNG_LSB];
            bipolar_r <= pwdata[`ACS_MODE_BIP];
            chan_r    <= pwdata[`ACS_MODE_CHAN];
        end else if (state_r != ST_IDLE && state_nxt == ST_IDLE) begin
            op_code_r <= `ACS_OP_IDLE;
        end
    end

    // filter register
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chop_enable_r          <= 1'b1;
            ac_excitation_enable_r <= 1'b0;
            word_div_r             <= `ACS_RST_DIV;
        end else if (wr_en && paddr == `ACS_OFS_FILTER) begin
            chop_enable_r          <= pwdata[`ACS_FILT_CHOP];
            ac_excitation_enable_r <= pwdata[`ACS_FILT_AC];
            word_div_r <= pwdata[`ACS_FILT_DIV_MSB:`ACS_FILT_DIV_LSB];
        end
    end

    // ------------------------------------------------------------
    // word period timer
    // ------------------------------------------------------------
    acs_word_timer u_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (cal_start),
        .run     (state_r != ST_IDLE),
        .div     (word_div_r),
        .tick    (word_tick)
    );

    assign step_done = word_tick && (tick_cnt_r + 6'h01 == step_len_r);

    // ------------------------------------------------------------
    // sequencer next state
    // ------------------------------------------------------------
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (cal_start) begin
                    state_nxt = ST_ZERO;
                end
            end
            ST_ZERO: begin
                if (cal_start) begin
                    state_nxt = ST_ZERO;
                end else if (step_done) begin
                    state_nxt = two_step_r ? ST_FULL : ST_IDLE;
                end
            end
            ST_FULL: begin
                if (cal_start) begin
                    state_nxt = ST_ZERO;
                end else if (step_done) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // state, step length and period count
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r    <= ST_IDLE;
            step_len_r <= `ACS_STEP_CHOP;
            tick_cnt_r <= 6'h00;
            two_step_r <= 1'b0;
            cal_chan_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (cal_start) begin
                // 22/24 per step; two steps give 44/48
                step_len_r <= chop_enable_r ? `ACS_STEP_CHOP
                                            : `ACS_STEP_NOCHOP;
                tick_cnt_r <= 6'h00;
                two_step_r <= (pwdata[`ACS_MODE_OP_MSB:`ACS_MODE_OP_LSB]
                               == `ACS_OP_IFS);
                cal_chan_r <= pwdata[`ACS_MODE_CHAN];
            end else if (step_done) begin
                tick_cnt_r <= 6'h00;
            end else if (word_tick) begin
                tick_cnt_r <= tick_cnt_r + 6'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // calibration sample capture
    // ------------------------------------------------------------
    // the last filter word of a step is the calibration point
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_r    <= 24'h000000;
            sample_ok_r <= 1'b0;
        end else if (cal_start || step_done) begin
            sample_ok_r <= 1'b0;
        end else if (filt_valid && state_r != ST_IDLE) begin
            sample_r    <= filt_data;
            sample_ok_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // coefficient store
    // ------------------------------------------------------------
    // a step with no filter word keeps the old coefficient
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            offs_r[0] <= `ACS_RST_COEF_OFFS;
            offs_r[1] <= `ACS_RST_COEF_OFFS;
            gain_r[0] <= `ACS_RST_COEF_GAIN;
            gain_r[1] <= `ACS_RST_COEF_GAIN;
        end else if (step_done && sample_ok_r && !cal_start) begin
            if (state_r == ST_ZERO) begin
                offs_r[cal_chan_r] <= sample_r;
            end else begin
                gain_r[cal_chan_r] <= sample_r;
            end
        end else if (wr_en) begin
            case (paddr)
                `ACS_OFS_OFFS0: offs_r[0] <= pwdata[23:0];
                `ACS_OFS_OFFS1: offs_r[1] <= pwdata[23:0];
                `ACS_OFS_GAIN0: gain_r[0] <= pwdata[23:0];
                `ACS_OFS_GAIN1: gain_r[1] <= pwdata[23:0];
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // ready line and analogue front-end controls
    // ------------------------------------------------------------
    // ready rises the cycle after the command, well inside one
    // modulator cycle, and falls as the last step ends
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_n     <= 1'b0;
            input_short <= 1'b0;
            fs_ref_sel  <= 1'b0;
            pga_range   <= 2'h0;
            ac_excite   <= 1'b0;
        end else begin
            ready_n   <= (state_nxt != ST_IDLE);
            // a mode write lands now; take its range so the first
            // calibration cycle never shows the previous gain
            pga_range <= mode_wr ?
                         pwdata[`ACS_MODE_RNG_MSB:`ACS_MODE_RNG_LSB]
                         : range_r;
            if (state_nxt == ST_IDLE) begin
                input_short <= 1'b0;
                fs_ref_sel  <= 1'b0;
                ac_excite   <= ac_excitation_enable_r;
            end else if (op_code_nxt_sys(cal_start, pwdata, op_code_r))
            begin
                input_short <= 1'b0;
                fs_ref_sel  <= 1'b0;
                ac_excite   <= ac_excitation_enable_r;
            end else begin
                // internal: shorted pair for zero, reference for full
                input_short <= (state_nxt == ST_ZERO);
                fs_ref_sel  <= (state_nxt == ST_FULL);
                ac_excite   <= 1'b0;
            end
        end
    end

    // picks the code a starting command writes, else the current code, and tests for system zero
    function op_code_nxt_sys;
        input        start;
        input [31:0] wd;
        input [2:0]  cur;
        begin
            op_code_nxt_sys = start ?
                (wd[`ACS_MODE_OP_MSB:`ACS_MODE_OP_LSB] == `ACS_OP_SZS)
                : (cur == `ACS_OP_SZS);
        end
    endfunction

    // ------------------------------------------------------------
    // conversion datapath
    // ------------------------------------------------------------
    // results only while converting, never from a calibration
    assign conv_on = (state_r == ST_IDLE) &&
                     (op_code_r == `ACS_OP_CONT ||
                      op_code_r == `ACS_OP_SINGLE);

    acs_corrector u_corr (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (filt_valid),
        .in_data   (filt_data),
        .enable    (conv_on),
        .bipolar   (bipolar_r),
        .offs      (offs_r[chan_r]),
        .gain      (gain_r[chan_r]),
        .out_valid (corr_valid),
        .out_data  (corr_data)
    );
endmodule // acs_cal_seq

// File: sim/acs_cal_monitor.sv
// port checker for the calibration sequencer
// assumes one pclk domain and the async low reset presetn
`timescale 1ns/1ns
`include "acs_regs.vh"
module acs_cal_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        ready_n,
    input wire logic        input_short,
    input wire logic        fs_ref_sel,
    input wire logic [1:0]  pga_range,
    input wire logic        ac_excite,
    input wire logic        corr_valid
);
    // ------
    // helpers
    // ------
    logic       int_r;
    logic [1:0] rng_r;
    wire mode_wr = psel && penable && pready && pwrite && !pslverr
        && paddr == `ACS_OFS_MODE;
    wire cal_go = mode_wr && pwdata[2] && pwdata[1:0] != 2'h3;
    // kind of run latched at the write, since op clears at the end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_r <= 1'h0;
            rng_r <= 2'h0;
        end else if (mode_wr) begin
            int_r <= !pwdata[1];
            rng_r <= pwdata[4:3];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ------
    // properties
    // ------
    wait_one_a: assert property ($rose(penable) && psel |=> pready)
        else $error("pready late");
    pready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held");
    err_gate_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata outside answer");
    cal_start_a: assert property (cal_go |=> ready_n)
        else $error("ready_n not raised");
    cal_min_a: assert property ($rose(ready_n) |-> ready_n[*8])
        else $error("calibration too short");
    dc_excite_a: assert property (ready_n && int_r |-> !ac_excite)
        else $error("ac excitation in internal run");
    short_gate_a: assert property (input_short |-> ready_n && int_r)
        else $error("input shorted outside internal run");
    fsref_gate_a: assert property (fs_ref_sel |-> ready_n && int_r)
        else $error("reference step outside internal run");
    pga_track_a: assert property (ready_n |-> pga_range == rng_r)
        else $error("gain differs from range bits");
    no_result_a: assert property (corr_valid |-> !ready_n)
        else $error("result during calibration");
    cover property ($rose(ready_n));
    cover property (pslverr);
    cover property (corr_valid);
endmodule // acs_cal_monitor

bind acs_cal_seq acs_cal_monitor mon_u (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .ready_n, .input_short, .fs_ref_sel, .pga_range, .ac_excite,
    .corr_valid);

// File: sim/acs_filt_model.sv
// filter word source standing in for the decimation filter
// assumes pclk; the bench holds word steady through each run
`timescale 1ns/1ns
module acs_filt_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        en,
    input  wire logic [3:0]  gap,
    input  wire logic [23:0] word,
    output logic             filt_valid,
    output logic [23:0]      filt_data
);
    // ------
    // strobe
    // ------
    logic [3:0] cnt_r;
    // one strobe every gap+1 cycles; off-strobe data is inverted
    // so a stale word is never mistaken for a good one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r      <= 4'h0;
            filt_valid <= 1'h0;
            filt_data  <= 24'h0;
        end else begin
            filt_valid <= en && cnt_r == gap;
            filt_data  <= (en && cnt_r == gap) ? word : ~word;
            cnt_r      <= (cnt_r == gap) ? 4'h0 : cnt_r + 4'h1;
        end
    end
endmodule // acs_filt_model

// File: sim/tb_adc_calibration_sequencer.sv
// self-checking bench for the calibration sequencer
// assumes the filter model on filt_* and an APB master here
`timescale 1ns/1ns
`include "acs_regs.vh"
module tb_adc_calibration_sequencer;
    // ------
    // signals
    // ------
    logic        pclk = 1'h0, presetn = 1'h0, en = 1'h0;
    logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0, err;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, rd;
    logic [3:0]  gap = 4'h2;
    logic [23:0] word = 24'h0;
    logic [47:0] pr;
    wire  [31:0] prdata;
    wire  [23:0] filt_data, corr_data;
    wire  [1:0]  pga_range;
    wire         pready, pslverr, filt_valid, ready_n, input_short;
    wire         fs_ref_sel, ac_excite, corr_valid;
    int          fail_count = 0, compares = 0, cv_n = 0;
    always #2 pclk = ~pclk;
    always @(posedge pclk) if (corr_valid === 1'h1) cv_n++;
    acs_cal_seq dut_u (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .filt_valid,
        .filt_data, .ready_n, .input_short, .fs_ref_sel, .pga_range,
        .ac_excite, .corr_valid, .corr_data);
    acs_filt_model filt_u (.pclk, .presetn, .en, .gap, .word,
        .filt_valid, .filt_data);
    // ------
    // tasks
    // ------
    task automatic tally_and_finish;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] ex, got);
        compares++;
        if (got !== ex) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, ex, got);
        end
    endtask
    // request held until pready is sampled high, then released
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (n >= 50) begin
            chk("pready", 1, pready);
            tally_and_finish();
        end
    endtask
    // start a run, check controls, time the busy window in cycles
    task automatic cal(input logic [31:0] md, input int len,
                       input logic sh, ac, input logic [1:0] pg);
        int n = 1;
        logic fs = 1'h0;
        apb(1'h1, `ACS_OFS_MODE, md);
        @(posedge pclk);
        chk("cal_ready", 1, ready_n);
        chk("cal_short", sh, input_short);
        chk("cal_ac", ac, ac_excite);
        chk("cal_pga", pg, pga_range);
        while (ready_n === 1'h1 && n < 2000) begin
            @(posedge pclk);
            n++;
            fs |= fs_ref_sel;
        end
        compares++;
        if (n < len || n > len + 4) begin
            fail_count++;
            $display("ERROR cal_len expected %0d seen %0d", len, n);
        end
        chk("cal_fsref", md[2:0] == `ACS_OP_IFS, fs);
        apb(1'h0, `ACS_OFS_MODE, 32'h0);
        chk("mode_idle", `ACS_OP_IDLE, rd[2:0]);
        if (n >= 2000)
            tally_and_finish();
    endtask
    // ------
    // sequence
    // ------
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, `ACS_OFS_FILTER, 32'h0);
        chk("filter_rst", {`ACS_RST_DIV, 16'h1}, rd);
        apb(1'h0, `ACS_OFS_GAIN1, 32'h0);
        chk("gain1_rst", {8'h0, `ACS_RST_COEF_GAIN}, rd);
        apb(1'h0, 12'h01C, 32'h0);
        chk("unmapped_err", 1, err);
        chk("unmapped_rd", 0, rd);
        en <= 1'h1;
        word <= 24'h123456;
        apb(1'h1, `ACS_OFS_FILTER, 32'h0001_0003);
        cal(32'h0000_000C, 22, 1'h1, 1'h0, 2'h1);
        apb(1'h0, `ACS_OFS_OFFS0, 32'h0);
        chk("offs0_izs", 32'h0012_3456, rd);
        apb(1'h0, `ACS_OFS_GAIN0, 32'h0);
        chk("gain0_izs", {8'h0, `ACS_RST_COEF_GAIN}, rd);
        word <= 24'h00ABCD;
        apb(1'h1, `ACS_OFS_FILTER, 32'h0001_0002);
        cal(32'h0000_0066, 24, 1'h0, 1'h1, 2'h0);
        apb(1'h0, `ACS_OFS_OFFS1, 32'h0);
        chk("offs1_szs", 32'h0000_ABCD, rd);
        word <= 24'h654321;
        apb(1'h1, `ACS_OFS_FILTER, 32'h0002_0003);
        cal(32'h0000_001D, 88, 1'h1, 1'h0, 2'h3);
        apb(1'h0, `ACS_OFS_GAIN0, 32'h0);
        chk("gain0_ifs", 32'h0065_4321, rd);
        apb(1'h0, `ACS_OFS_OFFS0, 32'h0);
        chk("offs0_ifs", 32'h0065_4321, rd);
        word <= 24'h654000;
        cal(32'h0000_0004, 44, 1'h1, 1'h0, 2'h0);
        apb(1'h0, `ACS_OFS_OFFS0, 32'h0);
        chk("offs0_rezero", 32'h0065_4000, rd);
        word <= 24'h654321;
        cal(32'h0000_0006, 44, 1'h0, 1'h1, 2'h0);
        apb(1'h0, `ACS_OFS_OFFS0, 32'h0);
        chk("offs0_sys", 32'h0065_4321, rd);
        chk("idle_results", 0, cv_n);
        word <= 24'h765432;
        pr = 48'h11_1111 * 48'h65_4321;
        apb(1'h1, `ACS_OFS_MODE, 32'h0000_0001);
        for (int n = 0; n < 100 && corr_valid !== 1'h1; n++)
            @(posedge pclk);
        chk("corr_valid", 1, corr_valid);
        chk("corr_data", pr[46:23], corr_data);
        apb(1'h1, `ACS_OFS_MODE, 32'h0);
        tally_and_finish();
    end
endmodule // tb_adc_calibration_sequencer
